// ===== tmcr_regs.sv
// Summary of operation
// - Software reset bit holds logic in reset, other fields return to default
// - Software reset reloads pin defaults from the last hardware reset capture
// - Range detect enable turns input frequency measurement on, default one
// - Lock enable drives lock pin high in locked state, low in other states; disabled pin floats
// - Nonzero force field pins the DPLL state; zero restores automatic operation
// - Force codes: free-run, holdover, unused, locked, prelock2, prelock, loss
// - Oscillator edge bit: zero rising, one falling, default zero
// - Zero-offset holdover bit selects 0ppm holdover, else digital holdover
// - Carrier rate bit sets code-one inputs to 2048 or 1544 kHz
// - Hardware reset loads carrier rate and both family bits from pin
// - Synth2 alternate bit picks E1/DS1 multiples or alternate rates
// - Synth2 normal set gives 1,2,4,8 times family base rate
// - Synth2 alternate set: 19.44, 38.88, 6.312 or 10 MHz
// - Synth1 gives 1,2,4,8 times its family base rate
// - Format field: off, LVPECL, LVDS, LVDS; default LVDS
// - Auto bandwidth bit lets DPLL choose bandwidth, default one
// - Integral limit bit freezes integral path at limits, default one
// - Code-one inputs in any mode use the carrier rate selection
`timescale 1ns/10ps
`default_nettype none
`include "tmcr_defs.svh"

module tmcr_regs (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_carrier_rate_pin,
  input  wire logic [8:0] i_addr,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic [7:0] i_wdata,
  input  wire logic [2:0] i_dpll_state,
  output logic      [7:0] o_rdata,
  output logic            o_core_reset,
  output logic            o_input_rate_code_range_detect_en,
  output logic            o_lock,
  output logic            o_lock_oe_n,
  output logic      [2:0] o_pll_state_force,
  output logic            o_state_force_active,
  output logic            o_osc_edge_select,
  output logic            o_zero_offset_holdover,
  output logic            o_carrier_rate_select,
  output logic     [15:0] o_code1_rate_khz,
  output logic            o_synth1_family,
  output logic            o_synth2_family,
  output logic            o_synth2_alt_set,
  output logic      [1:0] o_synth1_multiple,
  output logic      [1:0] o_synth2_multiple,
  output logic     [15:0] o_synth1_input_rate_code_khz,
  output logic     [15:0] o_synth2_input_rate_code_khz,
  output logic            o_synth2_input_rate_code_valid,
  output logic      [1:0] o_diff_out_format,
  output logic            o_diff_out_powerdown,
  output logic            o_diff_out_lvpecl,
  output logic      [7:0] o_pecl_swing_adj,
  output logic            o_auto_bandwidth_select,
  output logic            o_integral_freeze_at_limit
);

  tmcr_pkg::tmcr_state_t st_ff;
  tmcr_pkg::tmcr_state_t nxt_st;

  // Defaults of every field; pin-seeded fields take the given strap
  function automatic tmcr_pkg::tmcr_state_t field_defaults(
    input logic strap
  );
    tmcr_pkg::tmcr_state_t d;
    d           = '0;
    d.range_det = `TMCR_RANGE_RST;
    d.force_st  = tmcr_pkg::ST_AUTO;
    d.carrier   = strap;
    d.s2_fam    = strap;
    d.s1_fam    = strap;
    d.fmt       = tmcr_tmcr_fmt_cast(`TMCR_FMT_RST);
    d.auto_bw   = `TMCR_AUTO_BW_RST;
    d.int_frz   = `TMCR_INT_FRZ_RST;
    d.page      = `TMCR_PAGE_RST;
    d.adj       = `TMCR_ADJ_RST;
    d.strap     = strap;
    d.lock_oe_n = 1'b1;
    return d;
  endfunction : field_defaults

  function automatic tmcr_pkg::tmcr_fmt_t tmcr_tmcr_fmt_cast(
    input logic [1:0] v
  );
    return tmcr_pkg::tmcr_fmt_t'(v);
  endfunction : tmcr_tmcr_fmt_cast

  // One times, two, four or eight times the family base rate
  function automatic logic [15:0] multiple_rate(
    input logic       fam,
    input logic [1:0] mult
  );
    logic [15:0] base;
    base = fam ? `TMCR_DS1_KHZ : `TMCR_E1_KHZ;
    return base << mult;
  endfunction : multiple_rate

  // Register read image; unused positions show their defaults
  function automatic logic [7:0] read_image(
    input tmcr_pkg::tmcr_state_t s,
    input logic [8:0]            a
  );
    logic [7:0] r;
    r = 8'h00;
    case (a)
      `TMCR_ADDR_MC1: begin
        r = `TMCR_MC1_FILL;
        r[`TMCR_MC1_RST]  = s.sw_rst;
        r[`TMCR_MC1_RANGE] = s.range_det;
        r[`TMCR_MC1_LOCK] = s.lock_en;
        r[2:0]            = s.force_st;
      end
      `TMCR_ADDR_MC3: begin
        r = `TMCR_MC3_FILL;
        r[`TMCR_MC3_EDGE]    = s.edge_sel;
        r[`TMCR_MC3_ZOH]     = s.zoh;
        r[`TMCR_MC3_CARRIER] = s.carrier;
      end
      `TMCR_ADDR_MC6: begin
        r = `TMCR_MC6_FILL;
        r[`TMCR_MC6_S2ALT] = s.s2_alt;
        r[`TMCR_MC6_S2FAM] = s.s2_fam;
        r[`TMCR_MC6_S1FAM] = s.s1_fam;
      end
      `TMCR_ADDR_MC7: begin
        r = `TMCR_MC7_FILL;
        r[7:6] = s.s2_mult;
        r[5:4] = s.s1_mult;
      end
      `TMCR_ADDR_MC8: begin
        r = `TMCR_MC8_FILL;
        r[1:0] = s.fmt;
      end
      `TMCR_ADDR_MC9: begin
        r = `TMCR_MC9_FILL;
        r[`TMCR_MC9_AUTO_BW] = s.auto_bw;
        r[`TMCR_MC9_INT_FRZ] = s.int_frz;
      end
      `TMCR_ADDR_PAGE: r = s.page;
      // Adjustment location only visible while the page is open
      `TMCR_ADDR_ADJ:  r = (s.page == `TMCR_PAGE_OPEN) ? s.adj : 8'h00;
      default:         r = 8'h00;
    endcase
    return r;
  endfunction : read_image

  // Next-state logic for the whole bank
  always_comb begin
    nxt_st = st_ff;
    if (i_srst) begin
      // Pin is sampled on every cycle of hardware reset
      nxt_st = field_defaults(i_carrier_rate_pin);
    end else if (st_ff.sw_rst) begin
      // Held in reset: only the reset bit itself can be written
      nxt_st = field_defaults(st_ff.strap);
      nxt_st.sw_rst = st_ff.sw_rst;
      // Last read data is not a field and stands until the next read
      nxt_st.rdata  = st_ff.rdata;
      if (i_wr_en && i_addr == `TMCR_ADDR_MC1) begin
        nxt_st.sw_rst = i_wdata[`TMCR_MC1_RST];
      end
    end else if (i_wr_en) begin
      // Writes to unused positions are simply dropped
      case (i_addr)
        `TMCR_ADDR_MC1: begin
          nxt_st.sw_rst    = i_wdata[`TMCR_MC1_RST];
          nxt_st.range_det = i_wdata[`TMCR_MC1_RANGE];
          nxt_st.lock_en   = i_wdata[`TMCR_MC1_LOCK];
          nxt_st.force_st  =
            tmcr_pkg::tmcr_dpll_state_t'(i_wdata[2:0]);
          // Entering reset clears the other fields at once, so no
          // forced state or enable survives into the reset period
          if (i_wdata[`TMCR_MC1_RST]) begin
            nxt_st        = field_defaults(st_ff.strap);
            nxt_st.sw_rst = 1'b1;
            nxt_st.rdata  = st_ff.rdata;
          end
        end
        `TMCR_ADDR_MC3: begin
          nxt_st.edge_sel = i_wdata[`TMCR_MC3_EDGE];
          nxt_st.zoh      = i_wdata[`TMCR_MC3_ZOH];
          nxt_st.carrier  = i_wdata[`TMCR_MC3_CARRIER];
        end
        `TMCR_ADDR_MC6: begin
          nxt_st.s2_alt = i_wdata[`TMCR_MC6_S2ALT];
          nxt_st.s2_fam = i_wdata[`TMCR_MC6_S2FAM];
          nxt_st.s1_fam = i_wdata[`TMCR_MC6_S1FAM];
        end
        `TMCR_ADDR_MC7: begin
          nxt_st.s2_mult = i_wdata[7:6];
          nxt_st.s1_mult = i_wdata[5:4];
        end
        `TMCR_ADDR_MC8: nxt_st.fmt = tmcr_tmcr_fmt_cast(i_wdata[1:0]);
        `TMCR_ADDR_MC9: begin
          nxt_st.auto_bw = i_wdata[`TMCR_MC9_AUTO_BW];
          nxt_st.int_frz = i_wdata[`TMCR_MC9_INT_FRZ];
        end
        `TMCR_ADDR_PAGE: nxt_st.page = i_wdata;
        `TMCR_ADDR_ADJ: begin
          // Swing adjust only reachable through the open page
          if (st_ff.page == `TMCR_PAGE_OPEN) begin
            nxt_st.adj = i_wdata;
          end
        end
        default: nxt_st.page = st_ff.page;
      endcase
    end
    // Read data registered; reads during reset return the image too
    if (i_rd_en) begin
      nxt_st.rdata = read_image(st_ff, i_addr);
    end
    // Lock pin follows the reported DPLL state, floats when disabled
    nxt_st.lock_oe_n = ~st_ff.lock_en;
    nxt_st.lock      = st_ff.lock_en &&
                       (i_dpll_state == tmcr_pkg::ST_LOCKED);
    if (i_srst || st_ff.sw_rst) begin
      nxt_st.lock      = 1'b0;
      nxt_st.lock_oe_n = 1'b1;
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    st_ff <= nxt_st;
  end

  // Field outputs straight from the state register; core reset also ORs in i_srst
  assign o_rdata                    = st_ff.rdata;
  assign o_core_reset               = i_srst | st_ff.sw_rst;
  assign o_input_rate_code_range_detect_en     = st_ff.range_det;
  assign o_lock                     = st_ff.lock;
  assign o_lock_oe_n                = st_ff.lock_oe_n;
  assign o_pll_state_force          = st_ff.force_st;
  assign o_state_force_active       =
    (st_ff.force_st != tmcr_pkg::ST_AUTO);
  assign o_osc_edge_select          = st_ff.edge_sel;
  assign o_zero_offset_holdover     = st_ff.zoh;
  assign o_carrier_rate_select      = st_ff.carrier;
  assign o_synth1_family            = st_ff.s1_fam;
  assign o_synth2_family            = st_ff.s2_fam;
  assign o_synth2_alt_set           = st_ff.s2_alt;
  assign o_synth1_multiple          = st_ff.s1_mult;
  assign o_synth2_multiple          = st_ff.s2_mult;
  assign o_diff_out_format          = st_ff.fmt;
  assign o_pecl_swing_adj           = st_ff.adj;
  assign o_auto_bandwidth_select    = st_ff.auto_bw;
  assign o_integral_freeze_at_limit = st_ff.int_frz;

  // Code-one nominal rate shared by direct, 8 kHz and divider modes
  assign o_code1_rate_khz = st_ff.carrier ? `TMCR_DS1_KHZ
                                          : `TMCR_E1_KHZ;

  // Format decode; both upper codes mean LVDS
  assign o_diff_out_powerdown = (st_ff.fmt == tmcr_pkg::FMT_OFF);
  assign o_diff_out_lvpecl    = (st_ff.fmt == tmcr_pkg::FMT_LVPECL);

  // Synthesizer 1 rate
  assign o_synth1_input_rate_code_khz = multiple_rate(st_ff.s1_fam,
                                           st_ff.s1_mult);

  // Synthesizer 2 rate; undefined codes report zero and not valid
  always_comb begin
    o_synth2_input_rate_code_khz   = 16'h0000;
    o_synth2_input_rate_code_valid = 1'b1;
    if (!st_ff.s2_alt) begin
      o_synth2_input_rate_code_khz = multiple_rate(st_ff.s2_fam,
                                        st_ff.s2_mult);
    end else begin
      case ({st_ff.s2_fam, st_ff.s2_mult})
        3'h4:    o_synth2_input_rate_code_khz = `TMCR_OC3_KHZ;
        3'h5:    o_synth2_input_rate_code_khz = `TMCR_OC3X2_KHZ;
        3'h0:    o_synth2_input_rate_code_khz = `TMCR_DS2_KHZ;
        3'h2:    o_synth2_input_rate_code_khz = `TMCR_10M_KHZ;
        default: o_synth2_input_rate_code_valid = 1'b0;
      endcase
    end
  end

  // Checks on the bank's own behaviour
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_swrst_defaults: assert property (
    st_ff.sw_rst |-> (o_diff_out_format == 2'h2) && o_input_rate_code_range_detect_en
                     && (o_pll_state_force == 3'h0) && o_core_reset)
    else $error("software reset left a field off default");

  a_swrst_strap: assert property (
    st_ff.sw_rst |=> (o_carrier_rate_select == st_ff.strap)
                     && (o_synth1_family == st_ff.strap))
    else $error("software reset did not restore captured pin value");

  a_range_clear: assert property (
    (i_wr_en && i_addr == 9'h032 && !i_wdata[5] && !i_wdata[7]
     && !st_ff.sw_rst)
    |=> !o_input_rate_code_range_detect_en)
    else $error("range detect enable not cleared by write");

  a_lock_driven: assert property (
    (st_ff.lock_en && i_dpll_state == 3'h4 && !st_ff.sw_rst)
    |=> o_lock && !o_lock_oe_n)
    else $error("lock pin not driven high in locked state");

  a_lock_float: assert property (
    !st_ff.lock_en |=> o_lock_oe_n && !o_lock)
    else $error("lock pin driven while disabled");

  a_force_hold: assert property (
    (o_state_force_active && !i_wr_en) |=> $stable(o_pll_state_force))
    else $error("forced state changed without a write");

  a_code1_rate: assert property (
    o_code1_rate_khz == (o_carrier_rate_select ? 16'h0608 : 16'h0800))
    else $error("code one rate mismatch");

  a_pin_load: assert property (
    @(posedge i_clk) disable iff (1'b0)
    i_srst |=> (o_carrier_rate_select == $past(i_carrier_rate_pin))
               && (o_synth2_family == $past(i_carrier_rate_pin)))
    else $error("hardware reset did not load pin value");

  a_synth1_max: assert property (
    (o_synth1_multiple == 2'h3)
    |-> (o_synth1_input_rate_code_khz == (o_synth1_family ? 16'h3040 : 16'h4000)))
    else $error("synth1 eight times rate wrong");

  a_fmt_decode: assert property (
    o_diff_out_powerdown == (o_diff_out_format == 2'h0))
    else $error("output powerdown decode wrong");

  a_pecl_decode: assert property (
    o_diff_out_lvpecl == (o_diff_out_format == 2'h1))
    else $error("output level decode wrong");

  c_lock_out:  cover property (o_lock && !o_lock_oe_n);
  c_forced:    cover property (o_state_force_active ##1 !o_state_force_active);
  c_swrst:     cover property ($rose(st_ff.sw_rst) ##[1:8] !st_ff.sw_rst);
  c_adj_write: cover property (o_pecl_swing_adj == 8'h55);
  c_s2_undef:  cover property (!o_synth2_input_rate_code_valid);

endmodule : tmcr_regs
`default_nettype wire

// ===== tmcr_defs.svh
`ifndef TMCR_DEFS_SVH
`define TMCR_DEFS_SVH

// Register addresses on the processor port
`define TMCR_ADDR_MC1       9'h032
`define TMCR_ADDR_MC3       9'h034
`define TMCR_ADDR_MC6       9'h038
`define TMCR_ADDR_MC7       9'h039
`define TMCR_ADDR_MC8       9'h03A
`define TMCR_ADDR_MC9       9'h03B
`define TMCR_ADDR_PAGE      9'h1FF
`define TMCR_ADDR_ADJ       9'h1D8
`define TMCR_PAGE_OPEN      8'h01

// Field positions
`define TMCR_MC1_RST        7
`define TMCR_MC1_RANGE      5
`define TMCR_MC1_LOCK       4
`define TMCR_MC3_EDGE       5
`define TMCR_MC3_ZOH        4
`define TMCR_MC3_CARRIER    2
`define TMCR_MC6_S2ALT      7
`define TMCR_MC6_S2FAM      6
`define TMCR_MC6_S1FAM      5
`define TMCR_MC9_AUTO_BW    7
`define TMCR_MC9_INT_FRZ    3

// Reset values of fields
`define TMCR_RANGE_RST      1'b1
`define TMCR_FMT_RST        2'h2
`define TMCR_AUTO_BW_RST    1'b1
`define TMCR_INT_FRZ_RST    1'b1
`define TMCR_ADJ_RST        8'h00
`define TMCR_PAGE_RST       8'h00

// Unused bit positions read back their defaults
`define TMCR_MC1_FILL       8'h00
`define TMCR_MC3_FILL       8'hC2
`define TMCR_MC6_FILL       8'h1F
`define TMCR_MC7_FILL       8'h08
`define TMCR_MC8_FILL       8'h00
`define TMCR_MC9_FILL       8'h73

// Synthesizer and input rates in kHz
`define TMCR_E1_KHZ         16'h0800
`define TMCR_DS1_KHZ        16'h0608
`define TMCR_OC3_KHZ        16'h4BF0
`define TMCR_OC3X2_KHZ      16'h97E0
`define TMCR_DS2_KHZ        16'h18A8
`define TMCR_10M_KHZ        16'h2710

`endif

// ===== tmcr_pkg.sv
package tmcr_pkg;

  // Main DPLL state codes, shared by the force field and reported state
  typedef enum logic [2:0] {
    ST_AUTO     = 3'h0,
    ST_FREE_RUN = 3'h1,
    ST_HOLDOVER = 3'h2,
    ST_UNUSED   = 3'h3,
    ST_LOCKED   = 3'h4,
    ST_PRELOCK2 = 3'h5,
    ST_PRELOCK  = 3'h6,
    ST_LOSS     = 3'h7
  } tmcr_dpll_state_t;

  // Differential output signal format
  typedef enum logic [1:0] {
    FMT_OFF      = 2'h0,
    FMT_LVPECL   = 2'h1,
    FMT_LVDS     = 2'h2,
    FMT_LVDS_ALT = 2'h3
  } tmcr_fmt_t;

  // Entire state of the bank
  typedef struct packed {
    logic             sw_rst;
    logic             range_det;
    logic             lock_en;
    tmcr_dpll_state_t force_st;
    logic             edge_sel;
    logic             zoh;
    logic             carrier;
    logic             s2_alt;
    logic             s2_fam;
    logic             s1_fam;
    logic [1:0]       s2_mult;
    logic [1:0]       s1_mult;
    tmcr_fmt_t        fmt;
    logic             auto_bw;
    logic             int_frz;
    logic [7:0]       page;
    logic [7:0]       adj;
    logic             strap;
    logic [7:0]       rdata;
    logic             lock;
    logic             lock_oe_n;
  } tmcr_state_t;

endpackage : tmcr_pkg

// ===== tmcr_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmcr_defs.svh"

module tmcr_regs_tb_top;
  logic        i_clk;
  logic        i_srst;
  logic        i_carrier_rate_pin;
  logic [8:0]  i_addr;
  logic        i_wr_en;
  logic        i_rd_en;
  logic [7:0]  i_wdata;
  logic [2:0]  i_dpll_state;
  logic [7:0]  o_rdata;
  logic        o_core_reset;
  logic        o_range;
  logic        o_lock;
  logic        o_lock_oe_n;
  logic [2:0]  o_force;
  logic        o_force_act;
  logic        o_edge;
  logic        o_zoh;
  logic        o_carrier;
  logic [15:0] o_code1;
  logic        o_s1_fam;
  logic        o_s2_fam;
  logic        o_s2_alt;
  logic [1:0]  o_s1_mult;
  logic [1:0]  o_s2_mult;
  logic [15:0] o_s1_khz;
  logic [15:0] o_s2_khz;
  logic        o_s2_valid;
  logic [1:0]  o_fmt;
  logic        o_pd;
  logic        o_pecl;
  logic [7:0]  o_adj;
  logic        o_auto_bw;
  logic        o_int_frz;
  int          bad_count;
  int          checked;
  logic [15:0] alt_tab [8];
  logic [15:0] base;

  tmcr_regs uut (
    .i_clk                      (i_clk),
    .i_srst                     (i_srst),
    .i_carrier_rate_pin         (i_carrier_rate_pin),
    .i_addr                     (i_addr),
    .i_wr_en                    (i_wr_en),
    .i_rd_en                    (i_rd_en),
    .i_wdata                    (i_wdata),
    .i_dpll_state               (i_dpll_state),
    .o_rdata                    (o_rdata),
    .o_core_reset               (o_core_reset),
    .o_input_rate_code_range_detect_en     (o_range),
    .o_lock                     (o_lock),
    .o_lock_oe_n                (o_lock_oe_n),
    .o_pll_state_force          (o_force),
    .o_state_force_active       (o_force_act),
    .o_osc_edge_select          (o_edge),
    .o_zero_offset_holdover     (o_zoh),
    .o_carrier_rate_select      (o_carrier),
    .o_code1_rate_khz           (o_code1),
    .o_synth1_family            (o_s1_fam),
    .o_synth2_family            (o_s2_fam),
    .o_synth2_alt_set           (o_s2_alt),
    .o_synth1_multiple          (o_s1_mult),
    .o_synth2_multiple          (o_s2_mult),
    .o_synth1_input_rate_code_khz          (o_s1_khz),
    .o_synth2_input_rate_code_khz          (o_s2_khz),
    .o_synth2_input_rate_code_valid        (o_s2_valid),
    .o_diff_out_format          (o_fmt),
    .o_diff_out_powerdown       (o_pd),
    .o_diff_out_lvpecl          (o_pecl),
    .o_pecl_swing_adj           (o_adj),
    .o_auto_bandwidth_select    (o_auto_bw),
    .o_integral_freeze_at_limit (o_int_frz)
  );

  // Free-running 50 MHz clock
  always #10 i_clk = ~i_clk;

  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask : tick

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string what);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // Idle cycle after each strobe so no signal is set twice in one step
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    i_addr  = a;
    i_wdata = d;
    i_wr_en = 1'b1;
    tick();
    i_wr_en = 1'b0;
    tick();
  endtask : wr

  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    i_addr  = a;
    i_rd_en = 1'b1;
    tick();
    i_rd_en = 1'b0;
    tick();
    chk({8'h00, o_rdata}, {8'h00, exp}, "readback");
  endtask : rd

  task automatic hw_reset(input logic pin);
    i_carrier_rate_pin = pin;
    i_srst = 1'b1;
    repeat (6) tick();
    i_srst = 1'b0;
  endtask : hw_reset

  task automatic close_out();
    if (bad_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  // Main sequence; all waits are fixed counts given by the port contract
  initial begin
    i_clk = 1'b0;
    i_addr = 9'h000;
    i_wdata = 8'h00;
    i_wr_en = 1'b0;
    i_rd_en = 1'b0;
    i_dpll_state = 3'h0;
    bad_count = 0;
    checked = 0;
    alt_tab = '{16'h18A8, 16'h0000, 16'h2710, 16'h0000,
                16'h4BF0, 16'h97E0, 16'h0000, 16'h0000};
    hw_reset(1'b1);
    // Defaults, with the strap pin high
    rd(`TMCR_ADDR_MC1, 8'h20);
    rd(`TMCR_ADDR_MC3, 8'hC6);
    rd(`TMCR_ADDR_MC6, 8'h7F);
    rd(`TMCR_ADDR_MC7, 8'h08);
    rd(`TMCR_ADDR_MC8, 8'h02);
    rd(`TMCR_ADDR_MC9, 8'hFB);
    chk(o_code1, 16'h0608, "code one rate");
    chk(o_lock_oe_n, 1'b1, "lock pin floats");
    chk({o_s2_alt, o_s2_fam, o_s1_fam}, 3'h3, "synth straps");
    chk({o_s2_mult, o_s1_mult}, 4'h0, "synth multiples");
    chk(o_fmt, 2'h2, "format default");
    chk({o_range, o_auto_bw, o_int_frz}, 3'h7, "enable defaults");
    chk({o_core_reset, o_force_act}, 2'h0, "core running");
    rd(9'h033, 8'h00);
    // Unused bits hold their defaults whatever is written
    wr(`TMCR_ADDR_MC7, 8'hFF);
    rd(`TMCR_ADDR_MC7, 8'hF8);
    chk({o_s2_mult, o_s1_mult}, 4'hF, "multiples written");
    wr(`TMCR_ADDR_MC3, 8'h30);
    rd(`TMCR_ADDR_MC3, 8'hF2);
    chk({o_edge, o_zoh, o_carrier}, 3'h6, "edge holdover rate");
    chk(o_code1, 16'h0800, "code one rate");
    wr(`TMCR_ADDR_MC9, 8'h00);
    chk({o_auto_bw, o_int_frz}, 2'h0, "bandwidth bits");
    rd(`TMCR_ADDR_MC9, 8'h73);
    // Lock pin follows the locked state only while enabled
    i_dpll_state = 3'h4;
    wr(`TMCR_ADDR_MC1, 8'h10);
    chk(o_range, 1'b0, "range detect off");
    chk({o_lock, o_lock_oe_n}, 2'h2, "lock driven high");
    i_dpll_state = 3'h2;
    tick();
    tick();
    chk({o_lock, o_lock_oe_n}, 2'h0, "lock driven low");
    i_dpll_state = 3'h4;
    wr(`TMCR_ADDR_MC1, 8'h20);
    chk(o_lock_oe_n, 1'b1, "lock released");
    // Every force code, zero last to restore automatic operation
    for (int c = 7; c >= 0; c--) begin
      wr(`TMCR_ADDR_MC1, {5'h00, c[2:0]});
      chk(o_force, c[2:0], "force code");
      chk(o_force_act, c != 0, "force active");
      tick();
      chk(o_force, c[2:0], "force held");
    end
    // Synthesizer multiples, both families, normal and alternate sets
    for (int f = 0; f < 2; f++) begin
      for (int m = 0; m < 4; m++) begin
        base = f[0] ? 16'h0608 : 16'h0800;
        wr(`TMCR_ADDR_MC6, {1'b0, f[0], f[0], 5'h00});
        wr(`TMCR_ADDR_MC7, {m[1:0], m[1:0], 4'h0});
        chk(o_s1_khz, base << m, "synth1 rate");
        chk(o_s2_khz, base << m, "synth2 rate");
        chk(o_s2_valid, 1'b1, "normal set valid");
        wr(`TMCR_ADDR_MC6, {1'b1, f[0], f[0], 5'h00});
        chk(o_s2_alt, 1'b1, "alt set bit");
        chk(o_s2_khz, alt_tab[{f[0], m[1:0]}], "synth2 alt rate");
        chk(o_s2_valid, alt_tab[{f[0], m[1:0]}] != 0, "alt valid");
      end
    end
    // Format codes decode to power-down and level select
    for (int k = 0; k < 4; k++) begin
      wr(`TMCR_ADDR_MC8, {6'h00, k[1:0]});
      chk({o_pd, o_pecl}, {k == 0, k == 1}, "format decode");
      chk(o_fmt, k[1:0], "format field");
    end
    // Swing adjust reachable only while the page is open
    wr(`TMCR_ADDR_MC8, 8'h01);
    wr(`TMCR_ADDR_ADJ, 8'h55);
    chk(o_adj, 8'h00, "adjust page closed");
    wr(`TMCR_ADDR_PAGE, 8'h01);
    wr(`TMCR_ADDR_ADJ, 8'h55);
    rd(`TMCR_ADDR_ADJ, 8'h55);
    wr(`TMCR_ADDR_PAGE, 8'h00);
    chk(o_adj, 8'h55, "adjust kept");
    rd(`TMCR_ADDR_ADJ, 8'h00);
    wr(`TMCR_ADDR_MC8, 8'h02);
    wr(`TMCR_ADDR_PAGE, 8'h01);
    wr(`TMCR_ADDR_ADJ, 8'h00);
    wr(`TMCR_ADDR_PAGE, 8'h00);
    chk(o_adj, 8'h00, "adjust cleared");
    // Software reset keeps the strap from the last hardware reset
    i_carrier_rate_pin = 1'b0;
    wr(`TMCR_ADDR_MC3, 8'h00);
    wr(`TMCR_ADDR_MC1, 8'h80);
    chk(o_core_reset, 1'b1, "core held");
    wr(`TMCR_ADDR_MC8, 8'h00);
    rd(`TMCR_ADDR_MC1, 8'hA0);
    rd(`TMCR_ADDR_MC8, 8'h02);
    wr(`TMCR_ADDR_MC1, 8'h00);
    chk(o_core_reset, 1'b0, "core released");
    rd(`TMCR_ADDR_MC3, 8'hC6);
    rd(`TMCR_ADDR_MC6, 8'h7F);
    chk({o_carrier, o_s2_fam, o_s1_fam}, 3'h7, "captured straps");
    rd(`TMCR_ADDR_MC9, 8'hFB);
    // Hardware reset samples the strap again
    hw_reset(1'b0);
    rd(`TMCR_ADDR_MC3, 8'hC2);
    rd(`TMCR_ADDR_MC6, 8'h1F);
    chk(o_code1, 16'h0800, "code one rate");
    close_out();
  end
endmodule : tmcr_regs_tb_top

`default_nettype wire
